// ===== hw/dpw_chan.sv
// module: one channel's control, data and dac registers
module dpw_chan
	import dpw_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             ctrl_we,
	input  wire logic             main_we,
	input  wire logic             main_hi_we,
	input  wire logic             main_lo_we,
	input  wire logic             sub_we,
	input  wire logic [BUS_W-1:0] bus_in,
	input  wire logic             load_n_in,
	input  wire logic             clear_n_in,
	input  wire logic             coding_sel,
	output logic                  bias_hi_q,
	output logic                  bias_lo_q,
	output logic                  main_sub_q,
	output logic                  channel_standby_n_n_q,
	output logic                  chan_clr_q,
	output logic      [BUS_W-1:0] main_dac_q,
	output logic      [SUB_W-1:0] sub_dac_q
);

	logic             bias_hi_d;
	logic             bias_lo_d;
	logic             main_sub_d;
	logic             channel_standby_n_n_d;
	logic             chan_clr_d;
	logic [BUS_W-1:0] main_data_q;
	logic [BUS_W-1:0] main_data_d;
	logic [SUB_W-1:0] sub_data_q;
	logic [SUB_W-1:0] sub_data_d;
	logic [BUS_W-1:0] main_dac_d;
	logic [SUB_W-1:0] sub_dac_d;
	logic [SUB_W-1:0] sub_mid;

	// ************************************************************
	// next state
	// ************************************************************
	// the hardware clear is applied last so it beats any data write or load
	always_comb
	begin
		bias_hi_d   = bias_hi_q;
		bias_lo_d   = bias_lo_q;
		main_sub_d  = main_sub_q;
		channel_standby_n_n_d    = channel_standby_n_n_q;
		chan_clr_d  = chan_clr_q;
		main_data_d = main_data_q;
		sub_data_d  = sub_data_q;
		main_dac_d  = main_dac_q;
		sub_dac_d   = sub_dac_q;
		sub_mid     = coding_sel ? SUB_MID_OFFSET : SUB_MID_TWOS;
		if (ctrl_we)
		begin
			bias_hi_d  = bus_in[BIAS_HI_BIT];
			bias_lo_d  = bus_in[BIAS_LO_BIT];
			main_sub_d = bus_in[MAIN_SUB_BIT];
			channel_standby_n_n_d   = bus_in[CH_CHANNEL_STANDBY_N_BIT];
			chan_clr_d = bus_in[CH_CLR_BIT];
		end
		if (main_we)
			main_data_d = bus_in;
		if (main_hi_we)
			main_data_d[BUS_W-1:UPPER_LSB] = bus_in[BUS_W-1:UPPER_LSB];
		if (main_lo_we)
			main_data_d[LO_DST_MSB:0] = bus_in[LO_SRC_MSB:LO_SRC_LSB];
		if (sub_we)
			sub_data_d = bus_in[BUS_W-1:UPPER_LSB];
		// dac registers follow the data registers while load is low
		if (!load_n_in)
		begin
			main_dac_d = main_data_q;
			sub_dac_d  = sub_data_q;
		end
		if (!clear_n_in)
		begin
			main_data_d = MAIN_CLEAR_CODE;
			main_dac_d  = MAIN_CLEAR_CODE;
			sub_data_d  = sub_mid;
			sub_dac_d   = sub_mid;
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	// power-on defaults of the channel fields
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bias_hi_q   <= RST_BIAS;
			bias_lo_q   <= RST_BIAS;
			main_sub_q  <= RST_MAIN_SUB;
			channel_standby_n_n_q    <= RST_CH_CHANNEL_STANDBY_N_N;
			chan_clr_q  <= RST_CH_CLR;
			main_data_q <= MAIN_CLEAR_CODE;
			sub_data_q  <= SUB_MID_TWOS;
			main_dac_q  <= MAIN_CLEAR_CODE;
			sub_dac_q   <= SUB_MID_TWOS;
		end
		else
		begin
			bias_hi_q   <= bias_hi_d;
			bias_lo_q   <= bias_lo_d;
			main_sub_q  <= main_sub_d;
			channel_standby_n_n_q    <= channel_standby_n_n_d;
			chan_clr_q  <= chan_clr_d;
			main_data_q <= main_data_d;
			sub_data_q  <= sub_data_d;
			main_dac_q  <= main_dac_d;
			sub_dac_q   <= sub_dac_d;
		end
	end

endmodule

// ===== hw/dpw_pkg.sv
// package: constants for the parallel write port of the multi-channel dac
package dpw_pkg;

	// ************************************************************
	// sizes
	// ************************************************************
	localparam int CH_COUNT = 8;   // octal variant channel count
	localparam int ADDR_W   = 3;
	localparam int BUS_W    = 10;
	localparam int SUB_W    = 8;
	localparam int PIN_W    = 18;  // all synchronised pins together

	// ************************************************************
	// bus bit positions
	// ************************************************************
	localparam int CTRL_SEL_BIT  = 0;  // ctrl_reg_sel / data_bus_bit0
	localparam int HALF_SEL_BIT  = 1;  // byte_half_sel
	localparam int MUST_ZERO_BIT = 2;
	localparam int LOAD_FMT_BIT  = 7;
	localparam int CODING_BIT    = 6;
	localparam int PDN_BIT       = 5;
	localparam int SYS_STANDBY_BIT     = 4;
	localparam int SYS_CLEAR_BIT      = 3;
	localparam int BIAS_HI_BIT   = 9;
	localparam int BIAS_LO_BIT   = 8;
	localparam int MAIN_SUB_BIT  = 7;
	localparam int CH_CHANNEL_STANDBY_N_BIT   = 4;
	localparam int CH_CLR_BIT    = 3;
	localparam int UPPER_LSB     = 2;  // low end of the 8-bit field
	localparam int LO_SRC_MSB    = 3;  // byte mode low bits source
	localparam int LO_SRC_LSB    = 2;
	localparam int LO_DST_MSB    = 1;

	// ************************************************************
	// reset and clear values
	// ************************************************************
	localparam logic RST_LOAD_FMT   = 1'b0;
	localparam logic RST_CODING     = 1'b0;
	localparam logic RST_PDN        = 1'b1;
	localparam logic RST_SYS_STANDBY      = 1'b1;
	localparam logic RST_SYS_CLEAR       = 1'b0;
	localparam logic RST_BIAS       = 1'b0;
	localparam logic RST_MAIN_SUB   = 1'b0;
	localparam logic RST_CH_CHANNEL_STANDBY_N_N  = 1'b1;
	localparam logic RST_CH_CLR     = 1'b1;
	localparam logic [PIN_W-1:0] RST_PINS = 18'h3FFFF;
	localparam logic [BUS_W-1:0] MAIN_CLEAR_CODE = 10'h000;
	localparam logic [SUB_W-1:0] SUB_MID_OFFSET  = 8'h80;
	localparam logic [SUB_W-1:0] SUB_MID_TWOS    = 8'h00;

endpackage

// ===== hw/dpw_port.sv
// module: parallel write port decoding host writes into dac registers
//
// Operation
// - cs and write strobe with address and mode load the selected register
// - outputs come only from dac registers, copied from data on load
// - select pin high means data registers, low means control registers
// - ten-bit mode: stored main_sub_sel picks main or sub data register
// - control write: bus bit 0 low is system, high is channel
// - hardware clear forces main codes to the all-zero code
// - hardware clear forces sub codes to their midscale code
// - control words carry fields in bits 9..3, bit 2 must be zero, bit 0 steers
// - system fields: load_format, coding, power down, standby, clear
// - channel fields: bias selects, main_sub_sel, standby, clear
// - ten-bit mode: main takes all ten bits, sub takes bits 9..2
// - byte mode, bit 1 low: bits 9..2 become main upper byte
// - byte mode, bit 1 high: bits 3..2 become main low bits
// - byte mode: bus bit 0 picks main or sub, stored bit unused
// - sub write takes bits 9..2, bit 1 ignored, bit 0 selects in byte mode
// - each channel owns its control register, only addressed one changes
// - quad variant decodes two address pins for channels A to D
// - octal variant decodes three address pins for channels A to H
// - load_format zero is ten-bit loading, one is byte loading
// - byte mode: bit 0 low writes main, high writes sub
// - coding_sel zero is twos complement, one offset binary, all channels
// - reset: power_down_n, sys_standby, channel standby_n and clear set
module dpw_port
	import dpw_pkg::*;
#(
	parameter bit QUAD_VARIANT = 1'b0
)
(
	input  wire logic                  clk,
	input  wire logic                  reset_n,
	input  wire logic                  cs_n,
	input  wire logic                  wr_n,
	input  wire logic                  data_space_sel,
	input  wire logic                  addr_bit2,
	input  wire logic                  addr_bit1,
	input  wire logic                  addr_bit0,
	input  wire logic      [BUS_W-1:0] data_bus,
	input  wire logic                  load_outputs_n,
	input  wire logic                  hw_clear_n,
	output logic                       load_format,
	output logic                       coding_sel,
	output logic                       power_down_n,
	output logic                       sys_standby,
	output logic                       sys_clear,
	output logic        [CH_COUNT-1:0] bias_sel_hi,
	output logic        [CH_COUNT-1:0] bias_sel_lo,
	output logic        [CH_COUNT-1:0] main_sub_sel,
	output logic        [CH_COUNT-1:0] channel_standby_n,
	output logic        [CH_COUNT-1:0] channel_clear,
	output logic [CH_COUNT*BUS_W-1:0] main_dac_code,
	output logic [CH_COUNT*SUB_W-1:0] sub_dac_code
);

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [PIN_W-1:0]  pins_s1_q;
	logic [PIN_W-1:0]  pins_s2_q;
	logic [PIN_W-1:0]  pins_raw;
	logic              wr_prev_q;
	logic              wr_prev_d;
	logic              cs_s;
	logic              wr_s;
	logic              mode_s;
	logic [ADDR_W-1:0] addr_s;
	logic [BUS_W-1:0]  bus_s;
	logic              load_n_s;
	logic              clr_n_s;

	// all host pins are asynchronous, so every one passes two flops
	assign pins_raw = {cs_n, wr_n, data_space_sel, addr_bit2, addr_bit1,
		addr_bit0, data_bus, load_outputs_n, hw_clear_n};
	assign {cs_s, wr_s, mode_s, addr_s, bus_s, load_n_s, clr_n_s} =
		pins_s2_q;
	assign wr_prev_d = wr_s;

	// sync chain plus the strobe history for edge detection
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pins_s1_q <= RST_PINS;
			pins_s2_q <= RST_PINS;
			wr_prev_q <= 1'b1;
		end
		else
		begin
			pins_s1_q <= pins_raw;
			pins_s2_q <= pins_s1_q;
			wr_prev_q <= wr_prev_d;
		end
	end

	// ************************************************************
	// write decode
	// ************************************************************
	logic                wr_ev;
	logic [ADDR_W-1:0]   ch_idx;
	logic                sys_we;
	logic                ctrl_ok;
	logic [CH_COUNT-1:0] ctrl_we_v;
	logic [CH_COUNT-1:0] main_we_v;
	logic [CH_COUNT-1:0] hi_we_v;
	logic [CH_COUNT-1:0] lo_we_v;
	logic [CH_COUNT-1:0] sub_we_v;
	logic [CH_COUNT-1:0] ms_sel;
	logic                load_format_q;
	logic                load_format_d;
	logic                coding_q;
	logic                coding_d;
	logic                pdn_q;
	logic                pdn_d;
	logic                sys_standby_q;
	logic                sys_standby_d;
	logic                sys_clear_q;
	logic                sys_clear_d;

	// the strobe edge is taken on synced copies; the host must hold data,
	// address and mode steady for a few clocks around it
	assign wr_ev = wr_s & ~wr_prev_q & ~cs_s;

	// quad parts ignore the top address pin
	assign ch_idx = QUAD_VARIANT ? {1'b0, addr_s[ADDR_W-2:0]}
		: addr_s;

	// a control word with the must-be-zero bit set is dropped
	assign ctrl_ok = wr_ev & ~mode_s & ~bus_s[MUST_ZERO_BIT];
	assign sys_we  = ctrl_ok & ~bus_s[CTRL_SEL_BIT];

	// one-hot strobes to the channels
	always_comb
	begin
		ctrl_we_v = '0;
		main_we_v = '0;
		hi_we_v   = '0;
		lo_we_v   = '0;
		sub_we_v  = '0;
		if (ctrl_ok && bus_s[CTRL_SEL_BIT])
			ctrl_we_v[ch_idx] = 1'b1;
		if (wr_ev && mode_s)
		begin
			if (load_format_q)
			begin
				if (bus_s[CTRL_SEL_BIT])
					sub_we_v[ch_idx] = 1'b1;
				else if (bus_s[HALF_SEL_BIT])
					lo_we_v[ch_idx] = 1'b1;
				else
					hi_we_v[ch_idx] = 1'b1;
			end
			else if (ms_sel[ch_idx])
				sub_we_v[ch_idx] = 1'b1;
			else
				main_we_v[ch_idx] = 1'b1;
		end
	end

	// ************************************************************
	// system control register
	// ************************************************************
	// bits 9, 8 and 1 of a system write are don't-care
	always_comb
	begin
		load_format_d = load_format_q;
		coding_d      = coding_q;
		pdn_d         = pdn_q;
		sys_standby_d       = sys_standby_q;
		sys_clear_d        = sys_clear_q;
		if (sys_we)
		begin
			load_format_d = bus_s[LOAD_FMT_BIT];
			coding_d      = bus_s[CODING_BIT];
			pdn_d         = bus_s[PDN_BIT];
			sys_standby_d       = bus_s[SYS_STANDBY_BIT];
			sys_clear_d        = bus_s[SYS_CLEAR_BIT];
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			load_format_q <= RST_LOAD_FMT;
			coding_q      <= RST_CODING;
			pdn_q         <= RST_PDN;
			sys_standby_q       <= RST_SYS_STANDBY;
			sys_clear_q        <= RST_SYS_CLEAR;
		end
		else
		begin
			load_format_q <= load_format_d;
			coding_q      <= coding_d;
			pdn_q         <= pdn_d;
			sys_standby_q       <= sys_standby_d;
			sys_clear_q        <= sys_clear_d;
		end
	end

	assign load_format  = load_format_q;
	assign coding_sel   = coding_q;
	assign power_down_n = pdn_q;
	assign sys_standby  = sys_standby_q;
	assign sys_clear    = sys_clear_q;
	assign main_sub_sel = ms_sel;

	// ************************************************************
	// channels
	// ************************************************************
	// all channels share one coding choice and one load and clear level
	genvar gi;
	generate
		for (gi = 0; gi < CH_COUNT; gi++)
		begin : g_ch
			dpw_chan u_chan (
				.clk        (clk),
				.reset_n    (reset_n),
				.ctrl_we    (ctrl_we_v[gi]),
				.main_we    (main_we_v[gi]),
				.main_hi_we (hi_we_v[gi]),
				.main_lo_we (lo_we_v[gi]),
				.sub_we     (sub_we_v[gi]),
				.bus_in     (bus_s),
				.load_n_in  (load_n_s),
				.clear_n_in (clr_n_s),
				.coding_sel (coding_q),
				.bias_hi_q  (bias_sel_hi[gi]),
				.bias_lo_q  (bias_sel_lo[gi]),
				.main_sub_q (ms_sel[gi]),
				.channel_standby_n_n_q   (channel_standby_n[gi]),
				.chan_clr_q (channel_clear[gi]),
				.main_dac_q (main_dac_code[gi*BUS_W +: BUS_W]),
				.sub_dac_q  (sub_dac_code[gi*SUB_W +: SUB_W])
			);
		end
	endgenerate

	// ************************************************************
	// checks
	// ************************************************************
	logic [ADDR_W-1:0] last_idx_q;
	logic [BUS_W-1:0]  last_bus_q;

	// remembers the last accepted write for the checks below
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			last_idx_q <= '0;
			last_bus_q <= '0;
		end
		else if (wr_ev)
		begin
			last_idx_q <= ch_idx;
			last_bus_q <= bus_s;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_data_wr;
		wr_ev && mode_s && clr_n_s;
	endsequence

	sequence s_load_gap;
		!load_n_s && clr_n_s && !wr_ev;
	endsequence

	property p_sys_write;
		sys_we |=> load_format_q == $past(bus_s[LOAD_FMT_BIT])
			&& coding_q == $past(bus_s[CODING_BIT])
			&& sys_standby_q == $past(bus_s[SYS_STANDBY_BIT]);
	endproperty
	a_sys_write: assert property (p_sys_write)
		else $error("system control write not stored");

	property p_chan_write;
		ctrl_ok && bus_s[CTRL_SEL_BIT] |=>
			ms_sel[last_idx_q] == last_bus_q[MAIN_SUB_BIT]
			&& channel_standby_n[last_idx_q] == last_bus_q[CH_CHANNEL_STANDBY_N_BIT]
			&& ((ms_sel ^ $past(ms_sel)) & ~(8'h01 << last_idx_q)) == '0;
	endproperty
	a_chan_write: assert property (p_chan_write)
		else $error("channel control write wrong or not isolated");

	property p_idle;
		!wr_ev |=> $stable({load_format_q, coding_q, pdn_q, sys_standby_q})
			&& $stable({ms_sel, channel_clear, bias_sel_hi});
	endproperty
	a_idle: assert property (p_idle)
		else $error("register changed without a write strobe");

	property p_main10;
		s_data_wr ##0 (!load_format_q && !ms_sel[ch_idx]) ##1 s_load_gap
			|=> main_dac_code[last_idx_q*BUS_W +: BUS_W] == last_bus_q;
	endproperty
	a_main10: assert property (p_main10)
		else $error("ten-bit main write did not reach dac");

	property p_byte_hi;
		s_data_wr ##0 (load_format_q && !bus_s[HALF_SEL_BIT]
			&& !bus_s[CTRL_SEL_BIT]) ##1 s_load_gap |=>
			main_dac_code[last_idx_q*BUS_W+UPPER_LSB +: SUB_W]
			== last_bus_q[BUS_W-1:UPPER_LSB];
	endproperty
	a_byte_hi: assert property (p_byte_hi)
		else $error("byte mode upper write wrong");

	property p_byte_lo;
		s_data_wr ##0 (load_format_q && bus_s[HALF_SEL_BIT]
			&& !bus_s[CTRL_SEL_BIT]) ##1 s_load_gap |=>
			main_dac_code[last_idx_q*BUS_W +: 2]
			== last_bus_q[LO_SRC_MSB:LO_SRC_LSB];
	endproperty
	a_byte_lo: assert property (p_byte_lo)
		else $error("byte mode low bits write wrong");

	property p_sub;
		s_data_wr ##0 (load_format_q ? bus_s[CTRL_SEL_BIT]
			: ms_sel[ch_idx]) ##1 s_load_gap |=>
			sub_dac_code[last_idx_q*SUB_W +: SUB_W]
			== last_bus_q[BUS_W-1:UPPER_LSB];
	endproperty
	a_sub: assert property (p_sub)
		else $error("sub write did not reach dac");

	property p_hold;
		load_n_s && clr_n_s |=> $stable(main_dac_code)
			&& $stable(sub_dac_code);
	endproperty
	a_hold: assert property (p_hold)
		else $error("dac register moved without load");

	property p_clear;
		!clr_n_s |=> main_dac_code == '0 && sub_dac_code ==
			{CH_COUNT{$past(coding_q) ? SUB_MID_OFFSET : SUB_MID_TWOS}};
	endproperty
	a_clear: assert property (p_clear)
		else $error("hardware clear codes wrong");

	property p_power_on;
		$rose(reset_n) |-> pdn_q && sys_standby_q && &channel_standby_n
			&& &channel_clear && !(|bias_sel_hi) && !(|bias_sel_lo);
	endproperty
	a_power_on: assert property (p_power_on)
		else $error("power-on defaults wrong");

endmodule

// ===== verif/dpw_host.sv
// host model: drives parallel write cycles into the dac port
module dpw_host
	import dpw_pkg::*;
(
	input  wire logic             clk,
	output logic                  cs_n,
	output logic                  wr_n,
	output logic                  data_space_sel,
	output logic                  addr_bit2,
	output logic                  addr_bit1,
	output logic                  addr_bit0,
	output logic      [BUS_W-1:0] data_bus
);
	timeunit 1ns;
	timeprecision 1ns;

	// ************************************************************
	// idle pins
	// ************************************************************
	// idle host: strobe and select high, bus parked
	initial
	begin
		cs_n = 1'b1;
		wr_n = 1'b1;
		data_space_sel = 1'b0;
		{addr_bit2, addr_bit1, addr_bit0} = 3'h0;
		data_bus = 10'h000;
	end

	// ************************************************************
	// write cycle
	// ************************************************************
	// pins are held 4 clocks before and 5 after the strobe rise, since
	// the port samples them two flops late
	task automatic wr_cycle(input logic sel, input logic [2:0] addr,
		input logic [BUS_W-1:0] val, input logic chip_on);
		@(posedge clk);
		data_space_sel <= sel;
		{addr_bit2, addr_bit1, addr_bit0} <= addr;
		data_bus <= val;
		cs_n <= ~chip_on;
		wr_n <= 1'b0;
		repeat (4) @(posedge clk);
		wr_n <= 1'b1;
		repeat (5) @(posedge clk);
		cs_n <= 1'b1;
		// released bus shows the inverse, never a stale copy
		data_bus <= ~val;
		data_space_sel <= ~sel;
		@(posedge clk);
	endtask
endmodule

// ===== verif/tb_top.sv
// testbench: scenarios for the parallel write port of the dac
module tb_top
	import dpw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic                      clk;
	logic                      reset_n;
	logic                      load_outputs_n;
	logic                      hw_clear_n;
	logic                      cs_n;
	logic                      wr_n;
	logic                      data_space_sel;
	logic                      addr_bit2;
	logic                      addr_bit1;
	logic                      addr_bit0;
	logic          [BUS_W-1:0] data_bus;
	logic                      load_format;
	logic                      coding_sel;
	logic                      power_down_n;
	logic                      sys_standby;
	logic                      sys_clear;
	logic       [CH_COUNT-1:0] bias_sel_hi;
	logic       [CH_COUNT-1:0] bias_sel_lo;
	logic       [CH_COUNT-1:0] main_sub_sel;
	logic       [CH_COUNT-1:0] channel_standby_n;
	logic       [CH_COUNT-1:0] channel_clear;
	logic       [CH_COUNT-1:0] quad_clear;
	logic [CH_COUNT*BUS_W-1:0] main_dac_code;
	logic [CH_COUNT*SUB_W-1:0] sub_dac_code;
	int                        failures;
	int                        n_checks;

	// ************************************************************
	// clock, host and device
	// ************************************************************
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	dpw_host i_host (.clk(clk), .cs_n(cs_n), .wr_n(wr_n),
		.data_space_sel(data_space_sel), .addr_bit2(addr_bit2),
		.addr_bit1(addr_bit1), .addr_bit0(addr_bit0),
		.data_bus(data_bus));

	dpw_port #(.QUAD_VARIANT(1'b0)) i_dut (.clk(clk), .reset_n(reset_n),
		.cs_n(cs_n), .wr_n(wr_n), .data_space_sel(data_space_sel),
		.addr_bit2(addr_bit2), .addr_bit1(addr_bit1),
		.addr_bit0(addr_bit0), .data_bus(data_bus),
		.load_outputs_n(load_outputs_n), .hw_clear_n(hw_clear_n),
		.load_format(load_format), .coding_sel(coding_sel),
		.power_down_n(power_down_n), .sys_standby(sys_standby),
		.sys_clear(sys_clear), .bias_sel_hi(bias_sel_hi),
		.bias_sel_lo(bias_sel_lo), .main_sub_sel(main_sub_sel),
		.channel_standby_n(channel_standby_n),
		.channel_clear(channel_clear), .main_dac_code(main_dac_code),
		.sub_dac_code(sub_dac_code));

	// quad build on the same pins: addr_bit2 must be ignored there
	dpw_port #(.QUAD_VARIANT(1'b1)) i_dut_quad (.clk(clk),
		.reset_n(reset_n), .cs_n(cs_n), .wr_n(wr_n),
		.data_space_sel(data_space_sel), .addr_bit2(addr_bit2),
		.addr_bit1(addr_bit1), .addr_bit0(addr_bit0),
		.data_bus(data_bus), .load_outputs_n(load_outputs_n),
		.hw_clear_n(hw_clear_n), .load_format(), .coding_sel(),
		.power_down_n(), .sys_standby(), .sys_clear(),
		.bias_sel_hi(), .bias_sel_lo(), .main_sub_sel(),
		.channel_standby_n(), .channel_clear(quad_clear),
		.main_dac_code(), .sub_dac_code());

	// ************************************************************
	// compare and closing tasks
	// ************************************************************
	task automatic chk_bits(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t flags got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_code(input logic [9:0] got, input logic [9:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t code got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	function automatic logic [9:0] main_of(input int ch);
		return main_dac_code[ch*BUS_W +: BUS_W];
	endfunction

	function automatic logic [9:0] sub_of(input int ch);
		return {2'b00, sub_dac_code[ch*SUB_W +: SUB_W]};
	endfunction

	// ************************************************************
	// scenarios
	// ************************************************************
	// power-on state of every register
	task automatic t_reset();
		chk_bits({load_format, coding_sel, power_down_n, sys_standby,
			sys_clear}, 8'h06);
		chk_bits(bias_sel_hi | bias_sel_lo | main_sub_sel, 8'h00);
		chk_bits(channel_standby_n & channel_clear, 8'hFF);
		for (int ch = 0; ch < CH_COUNT; ch++)
		begin
			chk_code(main_of(ch) | sub_of(ch), 10'h000);
		end
	endtask

	// system control: refused writes first, then a real one
	task automatic t_sys();
		i_host.wr_cycle(1'b0, 3'h0, 10'h07C, 1'b1);
		chk_bits({coding_sel, sys_standby, sys_clear}, 8'h02);
		i_host.wr_cycle(1'b0, 3'h0, 10'h0F8, 1'b0);
		chk_bits({load_format, coding_sel, sys_clear}, 8'h00);
		i_host.wr_cycle(1'b0, 3'h5, 10'h30A, 1'b1);
		chk_bits({load_format, coding_sel, power_down_n, sys_standby,
			sys_clear}, 8'h01);
		chk_bits(channel_clear, 8'hFF);
	endtask

	// channel control: only the addressed channel moves
	task automatic t_chan();
		i_host.wr_cycle(1'b0, 3'h3, 10'h3F1, 1'b1);
		chk_bits(bias_sel_hi & bias_sel_lo & main_sub_sel, 8'h08);
		chk_bits(channel_clear, 8'hF7);
		i_host.wr_cycle(1'b0, 3'h6, 10'h201, 1'b1);
		chk_bits(bias_sel_hi, 8'h48);
		chk_bits(channel_standby_n, 8'hBF);
		chk_bits(channel_clear, 8'hB7);
		chk_bits(quad_clear, 8'hF3);
		chk_bits(sys_standby | load_format, 8'h00);
	endtask

	// ten-bit loads: held back until load, then routed by main_sub_sel
	task automatic t_ten();
		i_host.wr_cycle(1'b1, 3'h0, 10'h2A5, 1'b1);
		i_host.wr_cycle(1'b1, 3'h3, 10'h3C7, 1'b1);
		chk_code(main_of(0) | sub_of(3), 10'h000);
		@(posedge clk);
		load_outputs_n <= 1'b0;
		repeat (5) @(posedge clk);
		chk_code(main_of(0), 10'h2A5);
		chk_code(sub_of(3), 10'h0F1);
		chk_code(main_of(3), 10'h000);
		for (int ch = 0; ch < CH_COUNT; ch++)
		begin
			if (ch != 3)
			begin
				i_host.wr_cycle(1'b1, ch[2:0], {ch[2:0], 7'h2B}, 1'b1);
				chk_code(main_of(ch), {ch[2:0], 7'h2B});
			end
		end
	endtask

	// byte loads: halves and the bit 0 select, stored select ignored
	task automatic t_byte();
		i_host.wr_cycle(1'b0, 3'h0, 10'h0E0, 1'b1);
		chk_bits({load_format, coding_sel, power_down_n, sys_clear},
			8'h0E);
		i_host.wr_cycle(1'b1, 3'h3, 10'h2D0, 1'b1);
		i_host.wr_cycle(1'b1, 3'h3, 10'h3F6, 1'b1);
		chk_code(main_of(3), 10'h2D1);
		i_host.wr_cycle(1'b1, 3'h3, 10'h16B, 1'b1);
		i_host.wr_cycle(1'b1, 3'h5, 10'h30D, 1'b1);
		chk_code(sub_of(3), 10'h05A);
		chk_code(sub_of(5), 10'h0C3);
		chk_code(main_of(5), 10'h2AB);
		chk_code(main_of(3), 10'h2D1);
	endtask

	// hardware clear under both codings
	task automatic t_clear(input logic [9:0] sub_exp);
		@(posedge clk);
		hw_clear_n <= 1'b0;
		repeat (5) @(posedge clk);
		for (int ch = 0; ch < CH_COUNT; ch++)
		begin
			chk_code(main_of(ch), 10'h000);
			chk_code(sub_of(ch), sub_exp);
		end
		hw_clear_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask

	// ************************************************************
	// main sequence and watchdog
	// ************************************************************
	initial
	begin
		failures = 0;
		n_checks = 0;
		reset_n = 1'b0;
		load_outputs_n = 1'b1;
		hw_clear_n = 1'b1;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_sys();
		t_chan();
		t_ten();
		t_byte();
		t_clear(10'h080);
		i_host.wr_cycle(1'b0, 3'h0, 10'h020, 1'b1);
		t_clear(10'h000);
		complete_run();
	end

	// the tests need well under 1000 clocks; 5000 means a hang
	initial
	begin
		repeat (5000) @(posedge clk);
		failures++;
		complete_run();
	end
endmodule
